// ==== src/vrmc_pkg.sv ====
package vrmc_pkg;

    // APB carriers
    typedef struct packed {
        logic [31:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } vrmc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } vrmc_apb_rsp_t;

    // Register word indices; byte address is index * 4
    localparam int unsigned NUM_REGS     = 36;
    localparam logic [5:0] IDX_MODE      = 6'h00;
    localparam logic [5:0] IDX_CMD       = 6'h01;
    localparam logic [5:0] IDX_STATE     = 6'h02;
    localparam logic [5:0] IDX_PROF_TYPE = 6'h03;
    localparam logic [5:0] IDX_VL_TGT    = 6'h04;
    localparam logic [5:0] IDX_VL_DEM    = 6'h05;
    localparam logic [5:0] IDX_VL_ACT    = 6'h06;
    localparam logic [5:0] IDX_DIM_MUL   = 6'h07;
    localparam logic [5:0] IDX_DIM_DIV   = 6'h08;
    localparam logic [5:0] IDX_VL_ACC_DV = 6'h09;
    localparam logic [5:0] IDX_VL_ACC_DT = 6'h0A;
    localparam logic [5:0] IDX_VL_DEC_DV = 6'h0B;
    localparam logic [5:0] IDX_VL_DEC_DT = 6'h0C;
    localparam logic [5:0] IDX_VL_QS_DV  = 6'h0D;
    localparam logic [5:0] IDX_VL_QS_DT  = 6'h0E;
    localparam logic [5:0] IDX_VL_MIN    = 6'h0F;
    localparam logic [5:0] IDX_VL_MAX    = 6'h10;
    localparam logic [5:0] IDX_PV_TGT    = 6'h11;
    localparam logic [5:0] IDX_PV_DEM    = 6'h12;
    localparam logic [5:0] IDX_PV_ACT    = 6'h13;
    localparam logic [5:0] IDX_WIN       = 6'h14;
    localparam logic [5:0] IDX_WIN_TIME  = 6'h15;
    localparam logic [5:0] IDX_THR       = 6'h16;
    localparam logic [5:0] IDX_THR_TIME  = 6'h17;
    localparam logic [5:0] IDX_POLARITY  = 6'h18;
    localparam logic [5:0] IDX_PROF_ACC  = 6'h19;
    localparam logic [5:0] IDX_PROF_DEC  = 6'h1A;
    localparam logic [5:0] IDX_QS_DEC    = 6'h1B;
    localparam logic [5:0] IDX_MAX_PROF  = 6'h1C;
    localparam logic [5:0] IDX_MAX_MOTOR = 6'h1D;
    localparam logic [5:0] IDX_SLIP_MAX  = 6'h1E;
    localparam logic [5:0] IDX_SLIP_TIME = 6'h1F;
    localparam logic [5:0] IDX_JERK1     = 6'h20;
    localparam logic [5:0] IDX_JERK2     = 6'h21;
    localparam logic [5:0] IDX_JERK3     = 6'h22;
    localparam logic [5:0] IDX_JERK4     = 6'h23;

    // Field positions
    localparam int unsigned CMD_HALT_BIT   = 8;
    localparam int unsigned ST_REACHED_BIT = 10;
    localparam int unsigned ST_LIMIT_BIT   = 11;
    localparam int unsigned ST_ZERO_BIT    = 12;
    localparam int unsigned ST_SLIP_BIT    = 13;
    localparam int unsigned POL_VEL_BIT    = 6;

    // Encodings
    localparam logic [7:0] MODE_VL      = 8'h02;
    localparam logic [7:0] MODE_PV      = 8'h03;
    localparam logic [7:0] PROF_TRAP    = 8'h00;
    localparam logic [7:0] PROF_JERK    = 8'h03;

    // Reset values
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    localparam logic [31:0] RST_DIM       = 32'h0000_0001;
    localparam logic [31:0] RST_MAX_SPEED = 32'h0000_0BB8;

    // Control period
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_HZ        = 1000000000 / TICK_PERIOD_NS;

endpackage

// ==== src/vrmc_top.sv ====
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Profile type 3 runs jerk-limited ramps in profile velocity mode, outside quick stop, using the four jerk limits.
// - Profile type 0, the reset default, runs a trapezoidal ramp.
// - Writing 2 to operating_mode_select activates plain velocity mode.
// - Plain velocity mode uses only acceleration and deceleration ramps, never jerk.
// - Velocity mode halt: stopped while set; ramps up on clear, down on set.
// - Velocity mode state bit 11 high while any speed or acceleration limit acts.
// - Speeds convert between user units and rpm by multiplier and divisor.
// - Velocity acceleration is speed change divided by time in seconds.
// - Deceleration uses the same layout; host writes a positive speed change.
// - Target speed clamps to configured minimum and maximum.
// - Velocity quick-stop ramp comes from its own speed-change and time pair.
// - Velocity mode demanded and actual speed are readable.
// - Ramp generator tracks target within speed and acceleration limits.
// - Writing 3 to operating_mode_select activates profile velocity mode.
// - Profile mode halt: stopped while set; start ramp on clear, brake on set.
// - Profile mode bit 10 with halt: not reached, braking, in window, standstill.
// - Bit 10 sets only after speeds stay in window for window time.
// - Bit 12 clears when actual speed exceeds threshold for threshold time.
// - Closed loop: bit 13 sets when slip exceeds maximum beyond slip timeout.
// - Polarity bit 6 inverts the target speed sign.
// - Speed limited to smaller of max profile velocity and max motor speed.
// - Profile mode with operation enabled accelerates to target under all limits.
// - Ramp output is the demanded velocity and the velocity controller setpoint.
module vrmc_top #(
    parameter int unsigned TICK_CYCLES = vrmc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                    i_mclk,
    input  wire logic                    i_sys_rst,
    // APB slave
    input  wire vrmc_pkg::vrmc_apb_req_t i_apb,
    output vrmc_pkg::vrmc_apb_rsp_t      o_apb,
    // Drive state and feedback
    input  wire logic                    i_op_enabled,
    input  wire logic                    i_quick_stop,
    input  wire logic                    i_closed_loop,
    input  wire logic signed [31:0]      i_actual_rpm,
    // Velocity controller setpoint and state word
    output logic signed [31:0]           o_setpoint_rpm,
    output logic [15:0]                  o_state_word
);
    import vrmc_pkg::*;

    logic [31:0]        regs [0:NUM_REGS-1];
    logic [31:0]        tick_cnt;
    logic               tick;
    logic signed [31:0] demand;
    logic signed [31:0] act_user;
    logic [31:0]        vfrac;
    logic [31:0]        afrac;
    logic [31:0]        a_now;
    logic [15:0]        win_cnt;
    logic [15:0]        thr_cnt;
    logic [15:0]        slip_cnt;
    logic               halt_q;

    // Tick divider
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            tick_cnt <= 32'h0000_0000;
        end
        else if (tick_cnt >= TICK_CYCLES - 1)
        begin
            tick_cnt <= 32'h0000_0000;
        end
        else
        begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end
    assign tick = (tick_cnt >= TICK_CYCLES - 1);

    // Register access
    logic       acc_ph;
    logic [5:0] widx;
    logic       mapped;
    logic       ro_idx;
    assign acc_ph = i_apb.psel && i_apb.penable;
    assign widx   = i_apb.paddr[7:2];
    assign mapped = (i_apb.paddr[31:8] == 24'h00_0000) && (i_apb.paddr[1:0] == 2'h0)
                    && (32'(widx) < NUM_REGS);
    assign ro_idx = (widx == IDX_STATE) || (widx == IDX_VL_DEM) || (widx == IDX_VL_ACT)
                    || (widx == IDX_PV_DEM) || (widx == IDX_PV_ACT);

    function automatic logic [31:0] rst_val(input int unsigned idx);
        if (idx == 32'(IDX_DIM_MUL) || idx == 32'(IDX_DIM_DIV))
            return RST_DIM;
        else if (idx == 32'(IDX_MAX_PROF) || idx == 32'(IDX_MAX_MOTOR)
                 || idx == 32'(IDX_VL_MAX))
            return RST_MAX_SPEED;
        else
            return RST_ZERO;
    endfunction

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int unsigned i = 0; i < NUM_REGS; i++)
            begin
                regs[i] <= rst_val(i);
            end
        end
        else if (acc_ph && i_apb.pwrite && mapped && !ro_idx)
        begin
            regs[widx] <= i_apb.pwdata;
        end
    end

    always_comb
    begin
        o_apb.pready  = 1'b1;
        o_apb.pslverr = acc_ph && !mapped;
        o_apb.prdata  = 32'h0000_0000;
        if (acc_ph && mapped && !i_apb.pwrite)
        begin
            if (widx == IDX_STATE)
                o_apb.prdata = {16'h0000, o_state_word};
            else if (widx == IDX_VL_DEM || widx == IDX_PV_DEM)
                o_apb.prdata = demand;
            else if (widx == IDX_VL_ACT || widx == IDX_PV_ACT)
                o_apb.prdata = act_user;
            else
                o_apb.prdata = regs[widx];
        end
    end

    // Mode decode
    logic vl_mode;
    logic pv_mode;
    logic halt;
    logic jerk_on;
    assign vl_mode = (regs[IDX_MODE][7:0] == MODE_VL);
    assign pv_mode = (regs[IDX_MODE][7:0] == MODE_PV);
    assign halt    = regs[IDX_CMD][CMD_HALT_BIT];
    // Velocity mode never takes the jerk path
    assign jerk_on = pv_mode && (regs[IDX_PROF_TYPE][7:0] == PROF_JERK)
                     && !i_quick_stop;

    // Unit conversion; a zero factor is treated as one
    logic signed [63:0] dmul;
    logic signed [63:0] ddiv;
    logic signed [63:0] rpm_wide;
    logic signed [63:0] usr_wide;
    assign dmul     = (regs[IDX_DIM_MUL] == 32'h0) ? 64'sd1 : 64'(signed'(regs[IDX_DIM_MUL]));
    assign ddiv     = (regs[IDX_DIM_DIV] == 32'h0) ? 64'sd1 : 64'(signed'(regs[IDX_DIM_DIV]));
    assign rpm_wide = (64'(demand) * dmul) / ddiv;
    assign usr_wide = (64'(i_actual_rpm) * ddiv) / dmul;
    assign act_user = usr_wide[31:0];

    // Target shaping
    logic signed [31:0] tgt_raw;
    logic signed [31:0] tgt_pol;
    logic [31:0]        mag;
    logic [31:0]        spd_lim;
    logic [31:0]        hi;
    logic [31:0]        mag_cl;
    logic               clamped;
    logic signed [31:0] target;
    always_comb
    begin
        tgt_raw = vl_mode ? signed'(regs[IDX_VL_TGT]) : signed'(regs[IDX_PV_TGT]);
        tgt_pol = regs[IDX_POLARITY][POL_VEL_BIT] ? -tgt_raw : tgt_raw;
        mag     = tgt_pol[31] ? 32'(-tgt_pol) : 32'(tgt_pol);
        spd_lim = (regs[IDX_MAX_PROF] < regs[IDX_MAX_MOTOR]) ? regs[IDX_MAX_PROF]
                  : regs[IDX_MAX_MOTOR];
        hi      = (vl_mode && regs[IDX_VL_MAX] < spd_lim) ? regs[IDX_VL_MAX] : spd_lim;
        mag_cl  = mag;
        clamped = 1'b0;
        if (vl_mode && mag < regs[IDX_VL_MIN])
        begin
            mag_cl  = regs[IDX_VL_MIN];
            clamped = 1'b1;
        end
        if (mag_cl > hi)
        begin
            mag_cl  = hi;
            clamped = 1'b1;
        end
        target = tgt_pol[31] ? -signed'(mag_cl) : signed'(mag_cl);
    end

    // Goal: standstill while halted, quick-stopped or not in a speed mode
    logic signed [31:0] goal;
    logic               accel;
    assign goal  = (halt || i_quick_stop || !(vl_mode || pv_mode)) ? 32'sd0
                   : target;
    assign accel = (demand >= 0 && goal > demand) || (demand <= 0 && goal < demand);

    // Ramp rates in user units per second
    function automatic logic [31:0] per_sec(input logic [31:0] dv, input logic [31:0] dt);
        return (dt == 32'h0) ? dv : dv / dt;
    endfunction

    logic [31:0] rate;
    always_comb
    begin
        if (vl_mode)
        begin
            if (i_quick_stop)
                rate = per_sec(regs[IDX_VL_QS_DV], regs[IDX_VL_QS_DT]);
            else if (accel)
                rate = per_sec(regs[IDX_VL_ACC_DV], regs[IDX_VL_ACC_DT]);
            else
                rate = per_sec(regs[IDX_VL_DEC_DV], regs[IDX_VL_DEC_DT]);
        end
        else if (i_quick_stop)
            rate = regs[IDX_QS_DEC];
        else
            rate = accel ? regs[IDX_PROF_ACC] : regs[IDX_PROF_DEC];
    end

    // Jerk shaping: accel rises by the up-jerk, drops when the braking
    // distance a^2/2j reaches the remaining speed error
    logic [31:0]        j_up;
    logic [31:0]        j_dn;
    logic signed [32:0] err;
    logic [31:0]        err_mag;
    logic               taper;
    logic [32:0]        asum;
    logic [31:0]        astep;
    logic [31:0]        a_next;
    logic [31:0]        rate_eff;
    always_comb
    begin
        j_up    = accel ? regs[IDX_JERK1] : regs[IDX_JERK3];
        j_dn    = accel ? regs[IDX_JERK2] : regs[IDX_JERK4];
        err     = 33'(goal) - 33'(demand);
        err_mag = err[32] ? 32'(-err) : 32'(err);
        taper   = (64'(a_now) * 64'(a_now)) >= (64'(j_dn) * 64'(err_mag) * 64'd2);
        asum    = 33'(afrac) + 33'(taper ? j_dn : j_up);
        astep   = 32'(64'(asum) / 64'(TICK_HZ));
        if (taper)
            a_next = (a_now > astep + 32'h1) ? a_now - astep : 32'h0000_0001;
        else
            a_next = (a_now + astep > rate) ? rate : a_now + astep;
        rate_eff = jerk_on ? a_now : rate;
    end

    // Speed step per tick with a carried fraction, so slow ramps are exact
    logic [32:0] vsum;
    logic [31:0] vstep;
    always_comb
    begin
        vsum  = 33'(vfrac) + 33'(rate_eff);
        vstep = 32'(64'(vsum) / 64'(TICK_HZ));
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            demand <= 32'sh0000_0000;
            vfrac  <= 32'h0000_0000;
            afrac  <= 32'h0000_0000;
            a_now  <= 32'h0000_0000;
        end
        else if (!i_op_enabled)
        begin
            demand <= 32'sh0000_0000;
            vfrac  <= 32'h0000_0000;
            afrac  <= 32'h0000_0000;
            a_now  <= 32'h0000_0000;
        end
        else if (tick)
        begin
            vfrac <= 32'(64'(vsum) % 64'(TICK_HZ));
            afrac <= jerk_on ? 32'(64'(asum) % 64'(TICK_HZ)) : 32'h0000_0000;
            a_now <= jerk_on ? a_next : 32'h0000_0000;
            if (err_mag <= vstep)
                demand <= goal;
            else if (err[32])
                demand <= demand - signed'(vstep);
            else
                demand <= demand + signed'(vstep);
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_setpoint_rpm <= 32'sh0000_0000;
        else
            o_setpoint_rpm <= rpm_wide[31:0];
    end

    // Status conditions
    logic signed [32:0] dev;
    logic [31:0]        dev_mag;
    logic [31:0]        act_mag;
    logic               in_win;
    logic               above;
    logic               slipping;
    assign dev      = 33'(act_user) - 33'(demand);
    assign dev_mag  = dev[32] ? 32'(-dev) : 32'(dev);
    assign act_mag  = act_user[31] ? 32'(-act_user) : 32'(act_user);
    assign in_win   = (dev_mag <= regs[IDX_WIN]) && (demand == goal);
    assign above    = act_mag > regs[IDX_THR];
    assign slipping = i_closed_loop && (dev_mag > regs[IDX_SLIP_MAX]);

    // Saturating millisecond counters; one tick is one millisecond
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            win_cnt  <= 16'h0000;
            thr_cnt  <= 16'h0000;
            slip_cnt <= 16'h0000;
            halt_q   <= 1'b0;
        end
        else if (tick)
        begin
            halt_q   <= halt;
            // Window restarts when the halt bit flips the goal
            win_cnt  <= (!in_win || halt != halt_q) ? 16'h0000
                        : (win_cnt == 16'hFFFF) ? win_cnt : win_cnt + 16'h0001;
            thr_cnt  <= !above ? 16'h0000
                        : (thr_cnt == 16'hFFFF) ? thr_cnt : thr_cnt + 16'h0001;
            slip_cnt <= !slipping ? 16'h0000
                        : (slip_cnt == 16'hFFFF) ? slip_cnt : slip_cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_state_word <= 16'h1000;
        end
        else if (tick)
        begin
            o_state_word <= 16'h0000;
            // With halt set the goal is zero, so bit 10 then reads standstill
            o_state_word[ST_REACHED_BIT] <= pv_mode && in_win
                                            && (win_cnt >= regs[IDX_WIN_TIME][15:0]);
            o_state_word[ST_LIMIT_BIT]   <= vl_mode && (clamped
                                            || demand != goal);
            o_state_word[ST_ZERO_BIT]    <= !(above
                                            && thr_cnt >= regs[IDX_THR_TIME][15:0]);
            o_state_word[ST_SLIP_BIT]    <= slipping
                                            && (slip_cnt > regs[IDX_SLIP_TIME][15:0]);
        end
    end

endmodule // vrmc_top

// ==== test/vrmc_motor_model.sv ====
`timescale 1ns/1ps
module vrmc_motor_model (
    // Clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_sys_rst,
    // Demand and injected slip
    input  wire logic signed [31:0] i_setpoint_rpm,
    input  wire logic signed [31:0] i_slip_rpm,
    // Measured speed
    output logic signed [31:0]      o_actual_rpm
);
    // Ideal shaft one clock late; slip input models load error
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_actual_rpm <= '0;
        else
            o_actual_rpm <= i_setpoint_rpm + i_slip_rpm;
    end
endmodule // vrmc_motor_model

// ==== test/vrmc_top_sva.sv ====
`timescale 1ns/1ps
module vrmc_top_sva
    import vrmc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic                    i_mclk,
    input wire logic                    i_sys_rst,
    input wire vrmc_pkg::vrmc_apb_req_t i_apb,
    input wire vrmc_pkg::vrmc_apb_rsp_t o_apb,
    input wire logic                    i_op_enabled,
    input wire logic                    i_quick_stop,
    input wire logic                    i_closed_loop,
    input wire logic signed [31:0]      i_actual_rpm,
    input wire logic signed [31:0]      o_setpoint_rpm,
    input wire logic [15:0]             o_state_word
);
    wire acc = i_apb.psel && i_apb.penable;
    wire bad = i_apb.paddr[31:8] != 24'h0 || i_apb.paddr[7:2] > 6'h23 || i_apb.paddr[1:0] != 2'h0;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_ready_always: assert property (o_apb.pready)
        else $error("pready low");
    a_unmapped_err: assert property (acc && bad
        |-> o_apb.pslverr && o_apb.prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && !bad |-> !o_apb.pslverr)
        else $error("mapped access refused");
    a_idle_quiet: assert property (!acc |-> !o_apb.pslverr && o_apb.prdata == 32'h0)
        else $error("bus outputs active while idle");
    // Only valid while the tick period exceeds eight clocks
    a_state_hold: assert property ($changed(o_state_word)
        |=> $stable(o_state_word) [*8])
        else $error("state word moved between ticks");
    a_spare_zero: assert property ((o_state_word & 16'hC3FF) == 16'h0)
        else $error("spare state bits set");
    a_status_excl: assert property (!(o_state_word[10] && o_state_word[11]))
        else $error("reached and limit both set");
    a_slip_cause: assert property ($rose(o_state_word[13]) |-> $past(i_closed_loop))
        else $error("slip error without closed loop");
    a_zero_cause: assert property ($fell(o_state_word[12])
        |-> $past(i_actual_rpm) != 32'sh0)
        else $error("zero flag cleared at standstill");
    a_disable_zero: assert property (!i_op_enabled [*3] |-> o_setpoint_rpm == 32'sh0)
        else $error("setpoint while disabled");
    c_reached: cover property ($rose(o_state_word[10]));
    c_limit: cover property ($rose(o_state_word[11]));
    c_slip: cover property ($rose(o_state_word[13]));
    c_err: cover property (o_apb.pslverr);
endmodule // vrmc_top_sva

bind vrmc_top vrmc_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_apb(i_apb), .o_apb(o_apb),
    .i_op_enabled(i_op_enabled), .i_quick_stop(i_quick_stop), .i_closed_loop(i_closed_loop),
    .i_actual_rpm(i_actual_rpm), .o_setpoint_rpm(o_setpoint_rpm), .o_state_word(o_state_word));

// ==== test/vrmc_top_test.sv ====
`timescale 1ns/1ps
module vrmc_top_test;
    import vrmc_pkg::*;
    localparam int unsigned TK = 10;
    logic               i_mclk, i_sys_rst, op_en, qstop, cloop;
    vrmc_apb_req_t      i_apb;
    vrmc_apb_rsp_t      o_apb;
    logic signed [31:0] act, sp, slip;
    logic [15:0]        sw;
    int                 err_count, checked;

    vrmc_top #(.TICK_CYCLES(TK)) uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_apb(i_apb),
        .o_apb(o_apb), .i_op_enabled(op_en), .i_quick_stop(qstop), .i_closed_loop(cloop),
        .i_actual_rpm(act), .o_setpoint_rpm(sp), .o_state_word(sw));
    vrmc_motor_model plant (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_setpoint_rpm(sp),
        .i_slip_rpm(slip), .o_actual_rpm(act));

    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task bc(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    // Holds the request until pready is sampled high
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge i_mclk);
        i_apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge i_mclk);
        i_apb.penable <= 1'b1;
        @(posedge i_mclk);
        while (o_apb.pready !== 1'b1) @(posedge i_mclk);
        r = o_apb.prdata;
        e = o_apb.pslverr;
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
    endtask

    task wr(input logic [5:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, {24'h0, i, 2'h0}, d, r, e);
    endtask

    task rc(input logic [5:0] i, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, {24'h0, i, 2'h0}, 32'h0, r, e);
        check(r, exp);
    endtask

    task ticks(input int n);
        repeat (n * TK) @(posedge i_mclk);
    endtask

    // Setpoint change across exactly one control period
    task rate(input logic signed [31:0] exp);
        logic signed [31:0] v;
        @(posedge i_mclk);
        v = sp;
        repeat (TK) @(posedge i_mclk);
        check(sp - v, exp);
    endtask

    task t_reset;
        logic [31:0] r;
        logic        e;
        rc(IDX_PROF_TYPE, RST_ZERO);
        rc(IDX_DIM_MUL, RST_DIM);
        rc(IDX_MAX_PROF, RST_MAX_SPEED);
        rc(IDX_STATE, 32'h0000_1000);
        wr(IDX_VL_DEM, 32'h0000_0055);
        rc(IDX_VL_DEM, RST_ZERO);
        xfer(1'b0, 32'h0000_0090, 32'h0, r, e);
        bc(e, 1'b1);
        $display("reset test done");
    endtask

    task t_vl;
        wr(IDX_PROF_TYPE, {24'h0, PROF_JERK});
        wr(IDX_VL_ACC_DV, 32'h0001_86A0);
        wr(IDX_VL_ACC_DT, 32'h1);
        wr(IDX_VL_DEC_DV, 32'h0001_86A0);
        wr(IDX_VL_DEC_DT, 32'h1);
        wr(IDX_VL_QS_DV, 32'h0000_C350);
        wr(IDX_VL_QS_DT, 32'h1);
        wr(IDX_VL_TGT, 32'h1F4);
        wr(IDX_CMD, 32'h100);
        wr(IDX_MODE, {24'h0, MODE_VL});
        ticks(3);
        check(sp, 32'h0);
        wr(IDX_CMD, 32'h0);
        ticks(2);
        rate(32'sd100);
        bc(sw[11], 1'b1);
        ticks(6);
        rc(IDX_VL_DEM, 32'h1F4);
        check(sp, 32'h1F4);
        bc(sw[11], 1'b0);
        wr(IDX_DIM_MUL, 32'h2);
        repeat (3) @(posedge i_mclk);
        check(sp, 32'h3E8);
        wr(IDX_DIM_MUL, 32'h1);
        wr(IDX_VL_TGT, 32'h1388);
        ticks(30);
        rc(IDX_VL_DEM, 32'hBB8);
        bc(sw[11], 1'b1);
        wr(IDX_CMD, 32'h100);
        ticks(2);
        rate(-32'sd100);
        ticks(35);
        check(sp, 32'h0);
        wr(IDX_CMD, 32'h0);
        wr(IDX_VL_TGT, 32'h1F4);
        ticks(8);
        qstop <= 1'b1;
        ticks(2);
        rate(-32'sd50);
        ticks(12);
        check(sp, 32'h0);
        qstop <= 1'b0;
        wr(IDX_POLARITY, 32'h40);
        ticks(15);
        check(sp, 32'hFFFF_FE0C);
        wr(IDX_POLARITY, 32'h0);
        wr(IDX_PROF_TYPE, {24'h0, PROF_TRAP});
        $display("velocity test done");
    endtask

    task t_pv;
        wr(IDX_PROF_ACC, 32'h0001_86A0);
        wr(IDX_PROF_DEC, 32'h0001_86A0);
        wr(IDX_WIN, 32'h5);
        wr(IDX_WIN_TIME, 32'h3);
        wr(IDX_THR, 32'hA);
        wr(IDX_THR_TIME, 32'h2);
        wr(IDX_PV_TGT, 32'h190);
        wr(IDX_MODE, {24'h0, MODE_PV});
        ticks(25);
        check(sp, 32'h190);
        bc(sw[10], 1'b1);
        bc(sw[12], 1'b0);
        wr(IDX_CMD, 32'h100);
        // A tick on the write edge still sees the old halt bit
        ticks(1);
        rate(-32'sd100);
        bc(sw[10], 1'b0);
        ticks(12);
        bc(sw[10], 1'b1);
        bc(sw[12], 1'b1);
        wr(IDX_MAX_MOTOR, 32'hC8);
        wr(IDX_CMD, 32'h0);
        ticks(10);
        check(sp, 32'hC8);
        wr(IDX_MAX_MOTOR, RST_MAX_SPEED);
        for (int j = 0; j < 4; j++)
            wr(IDX_JERK1 + 6'(j), 32'h3B9A_CA00);
        wr(IDX_PROF_TYPE, {24'h0, PROF_JERK});
        ticks(25);
        check(sp, 32'h190);
        wr(IDX_QS_DEC, 32'h0000_C350);
        qstop <= 1'b1;
        ticks(2);
        rate(-32'sd50);
        qstop <= 1'b0;
        ticks(10);
        cloop <= 1'b1;
        wr(IDX_SLIP_MAX, 32'hA);
        wr(IDX_SLIP_TIME, 32'h2);
        slip <= 32'sd50;
        ticks(6);
        bc(sw[13], 1'b1);
        slip <= 32'sd0;
        ticks(3);
        bc(sw[13], 1'b0);
        op_en <= 1'b0;
        repeat (5) @(posedge i_mclk);
        check(sp, 32'h0);
        $display("profile test done");
    endtask

    initial
    begin
        err_count = 0;
        checked = 0;
        i_sys_rst = 1'b1;
        i_apb = '0;
        op_en = 1'b1;
        qstop = 1'b0;
        cloop = 1'b0;
        slip = 32'sd0;
        repeat (16) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_vl();
        t_pv();
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge i_mclk);
        err_count++;
        end_of_test();
    end
endmodule // vrmc_top_test
